// ==== include/cfg_loader_pkg.sv ====
package cfg_loader_pkg;

    // ****************************************
    // Flash geometry
    // ****************************************
    localparam int          FLASH_AW        = 15;
    localparam int          FLASH_DW        = 24;
    localparam int          PAGE_AW         = 10;
    localparam int          CFG_WORDS       = 8;
    localparam int          CFG_IW          = 3;
    localparam int          BOOT_SEQ_W      = 12;
    localparam int          BOOT_SEQ_WORD_IDX = 0;
    localparam logic [FLASH_AW-1:0] FLASH_TOP     = 15'h7FFF;
    localparam logic [FLASH_AW-1:0] CFG_BASE      = 15'h7FF8;
    localparam logic [FLASH_AW-PAGE_AW-1:0] LAST_PAGE = 5'h1F;
    localparam logic [FLASH_DW-1:0] ERASED_WORD   = 24'hFFFFFF;
    localparam logic [FLASH_DW-1:0] SHADOW_RESET  = 24'h000000;
    localparam logic [BOOT_SEQ_W-1:0] BOOT_SEQ_RESET = 12'hFFF;
    localparam logic [3:0]          EXEC_RST_CYC  = 4'h4;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0]
    {
        ST_SEQ_A  = 3'b000,
        ST_SEQ_B  = 3'b001,
        ST_LOAD   = 3'b011,
        ST_DONE   = 3'b010,
        ST_ERR    = 3'b110
    } load_state_t;

    typedef struct packed
    {
        logic                panel;
        logic [FLASH_AW-1:0] addr;
    } flash_req_t;

    typedef struct packed
    {
        logic                valid;
        logic [FLASH_DW-1:0] data;
    } flash_rsp_t;

endpackage : cfg_loader_pkg

// ==== rtl/cfg_exec_guard.sv ====
`timescale 1ns/10ps
module cfg_exec_guard
(
    // Clock and reset
    input  wire logic                           clock,
    input  wire logic                           rst_n,
    // Fetch watch
    input  wire logic                           fetch_valid,
    input  wire logic [cfg_loader_pkg::FLASH_AW-1:0] fetch_addr,
    // Reset request
    output logic                                exec_reset
);
    import cfg_loader_pkg::*;

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    wire        hit = fetch_valid && (fetch_addr >= CFG_BASE);

    // Stretched reset on fetch from configuration space
    assign cnt_d      = hit ? EXEC_RST_CYC : ((cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0);
    assign exec_reset = (cnt_q != 4'h0);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= 4'h0;
        else
            cnt_q <= cnt_d;
    end

endmodule : cfg_exec_guard

// ==== rtl/config_word_shadow_loader.sv ====
`timescale 1ns/10ps
module config_word_shadow_loader
(
    // Clock and reset
    input  wire logic                                clock,
    input  wire logic                                rst_n,
    input  wire logic                                ext_reset,
    // Mode
    input  wire logic                                dual_partition,
    // Flash read port
    output cfg_loader_pkg::flash_req_t               flash_req,
    output logic                                     flash_rd,
    input  wire cfg_loader_pkg::flash_rsp_t          flash_rsp,
    // Flash erase watch
    input  wire logic                                erase_done,
    input  wire logic                                erase_panel,
    input  wire logic [cfg_loader_pkg::FLASH_AW-1:0] erase_addr,
    // Fetch watch
    input  wire logic                                fetch_valid,
    input  wire logic [cfg_loader_pkg::FLASH_AW-1:0] fetch_addr,
    // Shadow outputs
    output logic [cfg_loader_pkg::CFG_WORDS*cfg_loader_pkg::FLASH_DW-1:0] shadow,
    output logic                                     active_panel,
    output logic                                     cfg_erased,
    // Core control
    output logic                                     core_reset,
    output logic                                     exec_reset
);
    import cfg_loader_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    load_state_t                 state_q;
    load_state_t                 state_d;
    logic [CFG_IW-1:0]           idx_q;
    logic                        rd_q;
    logic                        panel_q;
    logic [BOOT_SEQ_W-1:0]       seq_a_q;
    logic                        seq_valid_a_q;
    logic [FLASH_DW-1:0]         shadow_q [CFG_WORDS];
    logic                        erased_q [2];
    logic                        erase_hit;
    logic                        dev_reset;

    function automatic logic seq_valid(input logic [FLASH_DW-1:0] w);
        seq_valid = (w[2*BOOT_SEQ_W-1:BOOT_SEQ_W] == ~w[BOOT_SEQ_W-1:0]);
    endfunction : seq_valid

    function automatic logic [BOOT_SEQ_W-1:0] seq_num(input logic [FLASH_DW-1:0] w);
        seq_num = w[BOOT_SEQ_W-1:0];
    endfunction : seq_num

    // ****************************************
    // Reset sources
    // ****************************************
    cfg_exec_guard u_guard
    (
        .clock       (clock),
        .rst_n       (rst_n),
        .fetch_valid (fetch_valid),
        .fetch_addr  (fetch_addr),
        .exec_reset  (exec_reset)
    );

    assign dev_reset = ext_reset || exec_reset;

    // ****************************************
    // Sequencer
    // ****************************************
    wire         rsp_ok   = flash_rsp.valid;
    wire         last_idx = (idx_q == CFG_IW'(CFG_WORDS - 1));
    wire  [FLASH_DW-1:0] rsp_word = erased_q[panel_q] ? ERASED_WORD : flash_rsp.data;
    wire  [FLASH_DW-1:0] rsp_b = erased_q[1'b1] ? ERASED_WORD : flash_rsp.data;
    wire  [FLASH_DW-1:0] rsp_a = erased_q[1'b0] ? ERASED_WORD : flash_rsp.data;
    // Lower sequence number wins; an invalid field loses
    wire         pick_b   = seq_valid(rsp_b) &&
                            (!seq_valid_a_q || (seq_num(rsp_b) < seq_a_q));
    // Panel 0 sequence word, then panel 1, then the chosen panel
    wire         req_panel = (state_q == ST_SEQ_B) ||
                             ((state_q != ST_SEQ_A) && panel_q);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_SEQ_A: if (rsp_ok) state_d = ST_SEQ_B;
            ST_SEQ_B: if (rsp_ok) state_d = ST_LOAD;
            ST_LOAD:  if (rsp_ok && last_idx) state_d = ST_DONE;
            ST_DONE:  state_d = ST_DONE;
            default:  state_d = ST_ERR;
        endcase
    end

    assign flash_rd          = rd_q;
    assign flash_req.panel   = req_panel;
    assign flash_req.addr    = CFG_BASE + FLASH_AW'(idx_q);
    assign core_reset        = (state_q != ST_DONE) || dev_reset;
    assign active_panel      = panel_q;
    assign cfg_erased        = erased_q[panel_q];

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q       <= ST_SEQ_A;
            idx_q         <= '0;
            rd_q          <= 1'b0;
            panel_q       <= 1'b0;
            seq_a_q       <= BOOT_SEQ_RESET;
            seq_valid_a_q <= 1'b0;
        end
        else if (dev_reset)
        begin
            state_q       <= ST_SEQ_A;
            idx_q         <= '0;
            rd_q          <= 1'b0;
            panel_q       <= 1'b0;
            seq_a_q       <= BOOT_SEQ_RESET;
            seq_valid_a_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            // Strobe stays up through the whole load so each request stands
            rd_q    <= (state_d != ST_DONE) && (state_d != ST_ERR);
            if (state_q == ST_SEQ_A && rsp_ok)
            begin
                seq_a_q       <= seq_num(rsp_a);
                seq_valid_a_q <= seq_valid(rsp_a);
            end
            if (state_q == ST_SEQ_B && rsp_ok)
                panel_q <= dual_partition && pick_b;
            if (state_q == ST_LOAD && rsp_ok && !last_idx)
                idx_q <= idx_q + CFG_IW'(1);
        end
    end

    // ****************************************
    // Shadow registers
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < CFG_WORDS; g++)
        begin : g_shadow
            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                    shadow_q[g] <= SHADOW_RESET;
                else if (state_q == ST_LOAD && rsp_ok && idx_q == CFG_IW'(g))
                    shadow_q[g] <= rsp_word;
            end
            assign shadow[g*FLASH_DW +: FLASH_DW] = shadow_q[g];
        end
    endgenerate

    // ****************************************
    // Last page erase tracking
    // ****************************************
    assign erase_hit = erase_done && (erase_addr[FLASH_AW-1:PAGE_AW] == LAST_PAGE);

    generate
        for (g = 0; g < 2; g++)
        begin : g_erase
            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                    erased_q[g] <= 1'b0;
                else if (erase_hit && erase_panel == 1'(g))
                    erased_q[g] <= 1'b1;
                else if (flash_rd && rsp_ok && flash_req.panel == 1'(g)
                         && flash_rsp.data != ERASED_WORD)
                    erased_q[g] <= 1'b0;
            end
        end
    endgenerate

endmodule : config_word_shadow_loader

// ==== bench/loader_monitor.sv ====
`timescale 1ns/10ps
module loader_monitor
    import cfg_loader_pkg::*;
(
    // Watched ports
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ext_reset,
    input wire flash_req_t flash_req,
    input wire logic flash_rd,
    input wire flash_rsp_t flash_rsp,
    input wire logic erase_done,
    input wire logic erase_panel,
    input wire logic [FLASH_AW-1:0] erase_addr,
    input wire logic fetch_valid,
    input wire logic [FLASH_AW-1:0] fetch_addr,
    input wire logic [CFG_WORDS*FLASH_DW-1:0] shadow,
    input wire logic active_panel,
    input wire logic cfg_erased,
    input wire logic core_reset,
    input wire logic exec_reset
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_req_hold: assert property (flash_rd && !flash_rsp.valid && !ext_reset &&
        !exec_reset |=> flash_rd && $stable(flash_req)) else $error("request moved");
    a_req_top: assert property (flash_rd |-> flash_req.addr >= CFG_BASE)
        else $error("read low");
    a_core_held: assert property (flash_rd |-> core_reset) else $error("core early");
    a_exec_len: assert property (fetch_valid && fetch_addr >= CFG_BASE |->
        ##[0:1] exec_reset [*4]) else $error("exec short");
    a_dev_reload: assert property (ext_reset || exec_reset |=> core_reset && !flash_rd &&
        !flash_req.panel && flash_req.addr == CFG_BASE) else $error("no reload");
    a_shadow_hold: assert property (!core_reset && !$past(core_reset) |->
        $stable(shadow) && $stable(active_panel)) else $error("shadow moved");
    a_erase_flag: assert property (erase_done && erase_panel == active_panel &&
        erase_addr[FLASH_AW-1:PAGE_AW] == LAST_PAGE |-> ##[0:2] cfg_erased)
        else $error("erase missed");
endmodule : loader_monitor

bind config_word_shadow_loader loader_monitor u_mon (.*);

// ==== bench/flash_model.sv ====
`timescale 1ns/10ps
module flash_model
    import cfg_loader_pkg::*;
(
    // Read port and stored words
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire flash_req_t req,
    input  wire logic       rd,
    output flash_rsp_t      rsp,
    input  wire logic [FLASH_DW-1:0] seq0,
    input  wire logic [FLASH_DW-1:0] seq1,
    input  wire logic [1:0] wiped,
    input  wire logic       slow
);
    logic [1:0]          cnt_q;
    logic [FLASH_DW-1:0] word;
    assign word = wiped[req.panel] ? ERASED_WORD : req.addr == CFG_BASE ?
        (req.panel ? seq1 : seq0) : {7'h00, req.panel, 1'b0, req.addr};
    always_ff @(posedge clock)
    begin
        cnt_q     <= rd ? cnt_q + 2'h1 : 2'h0;
        rsp.valid <= rst_n && rd && !rsp.valid && (!slow || cnt_q == 2'h3);
        rsp.data  <= rd ? word : ~rsp.data;
    end
endmodule : flash_model

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    import cfg_loader_pkg::*;
    logic clock = 0, rst_n = 0, ext_reset = 0, dual_partition = 0, slow = 0;
    logic erase_done = 0, erase_panel = 0, fetch_valid = 0;
    logic flash_rd, active_panel, cfg_erased, core_reset, exec_reset;
    logic [FLASH_AW-1:0] erase_addr = '0, fetch_addr = '0;
    logic [FLASH_DW-1:0] seq0 = 24'hFFD002, seq1 = 24'hFFE001;
    logic [1:0] wiped = '0;
    logic [CFG_WORDS*FLASH_DW-1:0] shadow;
    flash_req_t flash_req;
    flash_rsp_t flash_rsp;
    int n_fail = 0, comparisons = 0;
    always #2 clock = ~clock;
    config_word_shadow_loader u_dut (.*);
    flash_model u_flash (.clock(clock), .rst_n(rst_n), .req(flash_req), .rd(flash_rd),
        .rsp(flash_rsp), .seq0(seq0), .seq1(seq1), .wiped(wiped), .slow(slow));
    task automatic check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        n_fail += int'(seen !== exp);
    endtask : check
    task automatic end_of_test;
        $display("fail %0d of %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic wait_load;
        for (int i = 0; i < 300 && core_reset !== 1'b0; i++)
            @(posedge clock) #1;
        check("load", core_reset, 1'b0);
        if (core_reset !== 1'b0)
            end_of_test();
    endtask : wait_load
    task automatic load_case(input logic d, input logic [23:0] s0, s1, input logic p, sl);
        @(posedge clock);
        {dual_partition, slow, seq0, seq1, ext_reset} <= {d, sl, s0, s1, 1'b1};
        @(posedge clock);
        ext_reset <= 1'b0;
        wait_load();
        check("panel", active_panel, p);
        for (int k = 0; k < CFG_WORDS; k++)
            check("word", shadow[k*FLASH_DW+:FLASH_DW], wiped[p] ? ERASED_WORD :
                k == BOOT_SEQ_WORD_IDX ? (p ? seq1 : seq0) : {7'h00, p, 1'b0, 15'(CFG_BASE + k)});
    endtask : load_case
    task automatic exec_case;
        @(posedge clock);
        {fetch_valid, fetch_addr} <= {1'b1, CFG_BASE};
        @(posedge clock);
        fetch_valid <= 1'b0;
        repeat (2) @(posedge clock);
        #1 check("exec", {exec_reset, core_reset}, 2'b11);
        wait_load();
    endtask : exec_case
    task automatic erase_case;
        @(posedge clock);
        {wiped, erase_done, erase_addr} <= {2'b01, 1'b1, 15'h7C00};
        @(posedge clock);
        erase_done <= 1'b0;
        repeat (3) @(posedge clock);
        #1 check("erased", cfg_erased, 1'b1);
        load_case(0, 24'hFFD002, 24'hFFE001, 0, 0);
    endtask : erase_case
    task automatic reset_case;
        repeat (3) @(posedge clock);
        #1 check("reset", {core_reset, shadow[22:0]}, {1'b1, 23'h0});
        @(posedge clock);
        rst_n <= 1'b1;
        wait_load();
        check("first", shadow[FLASH_DW-1:0], seq0);
        check("single", active_panel, 1'b0);
    endtask : reset_case
    initial
    begin
        reset_case();
        load_case(1, 24'hFFD002, 24'hFFE001, 1, 0);
        load_case(1, 24'hFFC003, 24'hFFC003, 0, 1);
        load_case(1, 24'hFFD002, 24'h123123, 0, 0);
        exec_case();
        erase_case();
        end_of_test();
    end
endmodule : testbench
